// [hdl/cms_pkg.sv]
/*
 * cms_pkg: constants for the clock multiplier and sleep control block.
 * Assumes a 50 MHz core clock; register map is word aligned on AHB-Lite.
 */
package cms_pkg;
    localparam int CMS_CLK_MHZ = 50;
    localparam int CMS_LOCK_TYP_US = 75;
    localparam int CMS_LOCK_MARGIN_PCT = 150;
    // lock wait: typical time plus the allowed overrun, rounded up to cycles
    localparam int CMS_LOCK_CYCLES = (CMS_LOCK_TYP_US * CMS_CLK_MHZ * (100 + CMS_LOCK_MARGIN_PCT) + 99) / 100;
    localparam int CMS_SLEEP_DELAY_MIN = 8;
    localparam int CMS_SLEEP_DELAY_MAX = 9;
    localparam int CMS_MULT_FACTOR = 4;

    localparam logic [7:0] CMS_ADDR_CSR = 8'h00;
    localparam logic [7:0] CMS_ADDR_IRQEN = 8'h04;
    localparam logic [7:0] CMS_ADDR_STATUS = 8'h08;

    localparam int CMS_SLEEP_HI = 15;
    localparam int CMS_SLEEP_LO = 10;
    localparam int CMS_GIE_BIT = 0;
    localparam int CMS_NONMASKABLE_ENABLE_BIT_BIT = 1;

    localparam logic [5:0] CMS_SLEEP_NONE = 6'h00;
    localparam logic [5:0] CMS_SLEEP_LIGHT_EN = 6'h09;
    localparam logic [5:0] CMS_SLEEP_LIGHT_ANY = 6'h11;
    localparam logic [5:0] CMS_SLEEP_DEEP = 6'h1a;
    localparam logic [5:0] CMS_SLEEP_DEEPEST = 6'h1c;

    typedef enum logic [4:0] {
        CMS_RUN = 5'h01,
        CMS_ARM = 5'h02,
        CMS_LIGHT = 5'h04,
        CMS_DEEP = 5'h08,
        CMS_DEEPEST = 5'h10
    } cms_state_t;
endpackage : cms_pkg

// [hdl/cms_sync.sv]
/*
 * cms_sync: two flip-flop level synchroniser.
 * Assumes the input is a level that stays at least two clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module cms_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : cms_sync
`default_nettype wire

// [hdl/cms_clock_sleep.sv]
/*
 * cms_clock_sleep: cpu clock source select and power-down sequencing.
 * Assumes one AHB-Lite master, a free running core clock standing in for the
 * reference input, and a cpu that reports irq requests and the sleep write.
 */
`timescale 1ns/1ps
`default_nettype none
module cms_clock_sleep
    import cms_pkg::*;
#(
    parameter int LOCK_CYCLES = CMS_LOCK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic multSelectPin,
    input wire logic unusedModePinA,
    input wire logic unusedModePinB,
    input wire logic [31:0] irqPending,
    input wire logic nmiPending,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [2:0] multFactor,
    output logic multBypass,
    output logic multOutEn,
    output logic multInEn,
    output logic cpuClkEn,
    output logic dmaClkEn,
    output logic irqLogicEn,
    output logic multLocked,
    output logic serviceIrq,
    output logic resumePulse
);
    logic rstSync1, rstN;
    logic selSync;
    logic [15:0] csr_q;
    logic [31:0] irqEn_q;
    cms_state_t state_q;
    logic [3:0] armCnt_q;
    logic [31:0] lockCnt_q;
    logic locked_q;
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic multSel_q;
    logic [5:0] sleepField;
    logic wakeAny, wakeEn, lightWake;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync1 <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstN <= rstSync1;
        end
    end

    // select pin synchronised; mode pins a and b are deliberately unread
    cms_sync #(.W(1)) uSelSync (
        .clk(core_clk),
        .rstN(rstN),
        .d(multSelectPin),
        .q(selSync)
    );

    // the synchroniser shows its reset value for two edges; latching earlier would lose the strap
    logic [1:0] syncFill_q;
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            syncFill_q <= 2'h0;
        end else if (clkEn) begin
            syncFill_q <= {syncFill_q[0], 1'b1};
        end
    end

    // mode is a strap: latch once after reset so a glitch cannot retune the clock
    logic strapDone_q;
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            multSel_q <= 1'b0;
            strapDone_q <= 1'b0;
        end else if (clkEn && syncFill_q[1] && !strapDone_q) begin
            multSel_q <= selSync;
            strapDone_q <= 1'b1;
        end
    end

    // factor one in bypass, four in multiply; registered so the outputs never glitch
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            multBypass <= 1'b1;
            multFactor <= 3'h1;
        end else if (clkEn) begin
            multBypass <= !multSel_q;
            multFactor <= multSel_q ? 3'(CMS_MULT_FACTOR) : 3'h1;
        end
    end

    // bus slave: zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end else if (clkEn && hready) begin
            wrPend_q <= hsel && htrans[1] && hwrite;
            wrAddr_q <= haddr[7:0];
        end
    end

    logic sleepWrite;
    assign sleepWrite = clkEn && wrPend_q && wrAddr_q == CMS_ADDR_CSR && state_q == CMS_RUN;

    // csr with sleep field; reset leaves no power-down
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            csr_q <= 16'h0000;
        end else if (clkEn) begin
            if (sleepWrite) begin
                csr_q <= hwdata[15:0];
            // same wake test as the sequencer, so a stray irq cannot clear the field and strand the level
            end else if (state_q == CMS_LIGHT && lightWake) begin
                csr_q[CMS_SLEEP_HI:CMS_SLEEP_LO] <= CMS_SLEEP_NONE;
            end
        end
    end
    assign sleepField = csr_q[CMS_SLEEP_HI:CMS_SLEEP_LO];

    logic irqEnWrite;
    assign irqEnWrite = clkEn && wrPend_q && wrAddr_q == CMS_ADDR_IRQEN && state_q == CMS_RUN;

    // a read is taken in its address phase, so hrdata already stands through the data phase
    logic rdAccept;
    assign rdAccept = clkEn && hready && hsel && htrans[1] && !hwrite;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            irqEn_q <= 32'h0000_0000;
        end else if (irqEnWrite) begin
            irqEn_q <= hwdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            hrdata <= 32'h0000_0000;
        end else if (rdAccept) begin
            unique case (haddr[7:0])
                CMS_ADDR_CSR: hrdata <= {16'h0000, csr_q};
                CMS_ADDR_IRQEN: hrdata <= irqEn_q;
                CMS_ADDR_STATUS: hrdata <= {24'h0, 3'h0, state_q};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    assign wakeAny = (|irqPending) || nmiPending;
    assign wakeEn = (|(irqPending & irqEn_q)) || nmiPending;

    // a wake only counts for the light flavour that was armed
    assign lightWake = (sleepField == CMS_SLEEP_LIGHT_ANY && wakeAny)
        || (sleepField == CMS_SLEEP_LIGHT_EN && wakeEn);

    // sleep sequencer; reserved codes are ignored
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            state_q <= CMS_RUN;
            armCnt_q <= 4'h0;
        end else if (clkEn) begin
            unique case (state_q)
                // reserved codes fall through: stored in the register, no level entered
                CMS_RUN: begin
                    if (sleepWrite && (hwdata[CMS_SLEEP_HI:CMS_SLEEP_LO] == CMS_SLEEP_LIGHT_EN
                        || hwdata[CMS_SLEEP_HI:CMS_SLEEP_LO] == CMS_SLEEP_LIGHT_ANY)) begin
                        state_q <= CMS_ARM;
                        armCnt_q <= 4'h1;
                    end else if (sleepWrite && hwdata[CMS_SLEEP_HI:CMS_SLEEP_LO] == CMS_SLEEP_DEEP) begin
                        state_q <= CMS_DEEP;
                    end else if (sleepWrite && hwdata[CMS_SLEEP_HI:CMS_SLEEP_LO] == CMS_SLEEP_DEEPEST) begin
                        state_q <= CMS_DEEPEST;
                    end
                end
                CMS_ARM: begin
                    // count to eight cycles after the write
                    if (armCnt_q == 4'(CMS_SLEEP_DELAY_MIN)) begin
                        state_q <= CMS_LIGHT;
                    end
                    armCnt_q <= armCnt_q + 4'h1;
                end
                CMS_LIGHT: begin
                    if ((sleepField == CMS_SLEEP_LIGHT_ANY && wakeAny)
                        || (sleepField == CMS_SLEEP_LIGHT_EN && wakeEn)) begin
                        state_q <= CMS_RUN;
                    end
                end
                CMS_DEEP: state_q <= CMS_DEEP;
                CMS_DEEPEST: state_q <= CMS_DEEPEST;
                default: state_q <= CMS_RUN;
            endcase
        end
    end

    // resume pulse, service only with enabled irq or nmi and both enables
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            resumePulse <= 1'b0;
            serviceIrq <= 1'b0;
        end else if (clkEn) begin
            resumePulse <= 1'b0;
            serviceIrq <= 1'b0;
            if (state_q == CMS_LIGHT && ((sleepField == CMS_SLEEP_LIGHT_ANY && wakeAny)
                || (sleepField == CMS_SLEEP_LIGHT_EN && wakeEn))) begin
                resumePulse <= 1'b1;
                serviceIrq <= wakeEn && csr_q[CMS_GIE_BIT] && csr_q[CMS_NONMASKABLE_ENABLE_BIT_BIT];
            end
        end
    end

    // relock wait after reset when multiplying
    // bypass needs no lock; the counter only matters when the strap asks for times four
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            lockCnt_q <= 32'h0;
            locked_q <= 1'b0;
        end else if (clkEn && !locked_q && strapDone_q) begin
            if (!multSel_q || lockCnt_q >= 32'(LOCK_CYCLES - 1)) begin
                locked_q <= 1'b1;
            end
            lockCnt_q <= lockCnt_q + 32'h1;
        end
    end
    assign multLocked = locked_q;

    // clock gating; nothing downstream runs until the multiplier reports lock
    always_comb begin
        cpuClkEn = 1'b0;
        irqLogicEn = 1'b0;
        multOutEn = 1'b1;
        multInEn = 1'b1;
        unique case (state_q)
            CMS_RUN, CMS_ARM: begin
                cpuClkEn = locked_q;
                irqLogicEn = locked_q;
            end
            // cpu gated at its boundary, irq logic and dma keep their clock
            CMS_LIGHT: begin
                irqLogicEn = locked_q;
            end
            // multiplier output stopped, every register keeps its value
            CMS_DEEP: begin
                multOutEn = 1'b0;
            end
            // multiplier input stopped too; relock follows the waking reset
            CMS_DEEPEST: begin
                multOutEn = 1'b0;
                multInEn = 1'b0;
            end
            default: begin
                cpuClkEn = 1'b0;
            end
        endcase
    end

    // dma shares the irq logic clock, so light sleep leaves transfers running
    assign dmaClkEn = irqLogicEn;
endmodule : cms_clock_sleep
`default_nettype wire

// [dv/cms_clock_sleep_sva.sv]
/* cms_clock_sleep_sva: port checks of clock select and sleep gating.
   assumes it is bound to cms_clock_sleep and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module cms_clock_sleep_sva (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [2:0] multFactor,
    input wire logic multBypass,
    input wire logic multOutEn,
    input wire logic multInEn,
    input wire logic cpuClkEn,
    input wire logic dmaClkEn,
    input wire logic irqLogicEn,
    input wire logic serviceIrq,
    input wire logic resumePulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_factor_sel: assert property (multFactor == (multBypass ? 3'h1 : 3'h4))
        else $error("factor mismatch");
    a_service_pair: assert property (serviceIrq |-> resumePulse)
        else $error("service without resume");
    a_resume_once: assert property (resumePulse |=> !resumePulse)
        else $error("resume too long");
    a_resume_run: assert property (resumePulse |-> cpuClkEn)
        else $error("resume with cpu gated");
    a_deep_held: assert property (!multOutEn |=> !multOutEn)
        else $error("deep sleep left");
    a_deepest_in: assert property (!multInEn |-> !multOutEn)
        else $error("input stop without output stop");
    a_deep_gates: assert property (!multOutEn |-> !(cpuClkEn || dmaClkEn || irqLogicEn))
        else $error("clock runs in deep sleep");
    a_light_dma: assert property ($fell(cpuClkEn) && multOutEn |-> dmaClkEn && irqLogicEn)
        else $error("dma gated in light sleep");
endmodule : cms_clock_sleep_sva
bind cms_clock_sleep cms_clock_sleep_sva cms_clock_sleep_sva_inst (.*);
`default_nettype wire

// [dv/cms_ref_src.sv]
/* cms_ref_src: far side model, strap pins and interrupt sources.
   assumes its tasks are called just after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module cms_ref_src (
    input wire logic core_clk,
    output logic multSelectPin,
    output logic unusedModePinA,
    output logic unusedModePinB,
    output logic [31:0] irqPending,
    output logic nmiPending
);
    logic [1:0] churn = 2'h0;
    always @(posedge core_clk) churn <= churn + 2'h1;
    assign unusedModePinA = churn[0];
    assign unusedModePinB = churn[1];
    task strap(input logic s);
        multSelectPin <= s;
    endtask : strap
    task irq(input logic [31:0] v, input logic m);
        irqPending <= v;
        nmiPending <= m;
    endtask : irq
endmodule : cms_ref_src
`default_nettype wire

// [dv/tb.sv]
/* tb: drives cms_clock_sleep over AHB-Lite, checks sleep and clock select.
   assumes a zero wait slave and a short lock count. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cms_pkg::*;
    localparam int LK = 16;
    logic core_clk = 0, reset_n = 0, clkEn = 1, hsel = 0, hwrite = 0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, irqPending, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, multFactor;
    logic hreadyout, hresp, multBypass, multOutEn, multInEn, cpuClkEn, dmaClkEn, irqLogicEn;
    logic multLocked, serviceIrq, resumePulse, multSelectPin, unusedModePinA, unusedModePinB, nmiPending;
    int n_errors = 0, samples_checked = 0, n;
    assign hready = hreadyout;
    cms_clock_sleep #(.LOCK_CYCLES(LK)) cms_clock_sleep_inst (.*);
    cms_ref_src cms_ref_src_inst (.*);
    initial forever #10 core_clk = ~core_clk;
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // bounded wait, sampled once the edge has settled
    task automatic wt(ref logic s, input logic v, input int lim);
        n = 0;
        do begin @(posedge core_clk); #1; n++; end while (s !== v && n < lim);
        if (s !== v) begin
            n_errors++;
            end_sim;
        end
    endtask : wt
    task automatic rdy;
        n = 0;
        do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 9);
        if (hready !== 1'b1) begin
            n_errors++;
            end_sim;
        end
    endtask : rdy
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        rd = hrdata;
    endtask : bus
    task automatic rst(input logic s);
        reset_n <= 1'b0;
        cms_ref_src_inst.strap(s);
        cms_ref_src_inst.irq(32'h0, 1'b0);
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        wt(multLocked, 1'b1, 60);
    endtask : rst
    task automatic nap(input logic [5:0] c, input logic [1:0] en, input logic [31:0] v, input logic s);
        bus(CMS_ADDR_CSR, 1'b1, {16'h0, c, 8'h0, en});
        wt(cpuClkEn, 1'b0, 20);
        chk("entry", n >= 8 && n <= 9, 32'h1);
        chk("dma", {dmaClkEn, irqLogicEn}, 32'h3);
        cms_ref_src_inst.irq(v, 1'b0);
        wt(resumePulse, 1'b1, 20);
        chk("svc", serviceIrq, s);
        cms_ref_src_inst.irq(32'h0, 1'b0);
        bus(CMS_ADDR_CSR, 1'b0, 32'h0);
        chk("csr", rd, {30'h0, en});
        $display("nap %h done", c);
    endtask : nap
    initial begin
        rst(1'b1);
        chk("lockx4", n > LK, 32'h1);
        chk("x4", {multBypass, multFactor}, 32'h4);
        bus(CMS_ADDR_CSR, 1'b0, 32'h0);
        chk("csr0", rd, 32'h0);
        chk("resp", {hreadyout, hresp}, 32'h2);
        bus(CMS_ADDR_IRQEN, 1'b1, 32'h8);
        clkEn <= 1'b0;
        bus(CMS_ADDR_IRQEN, 1'b1, 32'h1);
        clkEn <= 1'b1;
        bus(CMS_ADDR_IRQEN, 1'b0, 32'h0);
        chk("frozen", rd, 32'h8);
        $display("freeze done");
        nap(CMS_SLEEP_LIGHT_EN, 2'h3, 32'h8, 1'b1);
        nap(CMS_SLEEP_LIGHT_EN, 2'h1, 32'h8, 1'b0);
        nap(CMS_SLEEP_LIGHT_ANY, 2'h3, 32'h20, 1'b0);
        bus(CMS_ADDR_CSR, 1'b1, 32'h1400);
        bus(CMS_ADDR_STATUS, 1'b0, 32'h0);
        chk("rsvd", {rd[4:0], cpuClkEn}, 32'h3);
        bus(CMS_ADDR_CSR, 1'b1, {16'h0, CMS_SLEEP_DEEP, 10'h0});
        wt(multOutEn, 1'b0, 9);
        cms_ref_src_inst.irq(32'hffffffff, 1'b1);
        repeat (20) @(posedge core_clk);
        chk("deep", {multOutEn, multInEn, cpuClkEn}, 32'h2);
        $display("deep done");
        rst(1'b0);
        chk("x1", {multBypass, multFactor, n < LK}, 32'h13);
        bus(CMS_ADDR_CSR, 1'b0, 32'h0);
        chk("csr1", rd, 32'h0);
        bus(CMS_ADDR_CSR, 1'b1, {16'h0, CMS_SLEEP_DEEPEST, 10'h0});
        wt(multInEn, 1'b0, 9);
        chk("deepest", multOutEn, 32'h0);
        rst(1'b1);
        chk("relock", n > LK, 32'h1);
        $display("deepest done");
        end_sim;
    end
endmodule : tb
`default_nettype wire
